// *** hdl/btc_consts.vh ***
// Constants for the beam-type capture and feed-forward control block.
// Included by the divider and top design files; holds definitions only.
`ifndef BTC_CONSTS_VH
`define BTC_CONSTS_VH

// Register word offsets (byte address = index * 4)
`define BTC_IDX_MODE 4'h0
`define BTC_IDX_BEAM 4'h1
`define BTC_IDX_FWS 4'h2
`define BTC_IDX_SWS 4'h3
`define BTC_IDX_WWID 4'h4
`define BTC_IDX_SLOPE 4'h5
`define BTC_IDX_STAT 4'h6
`define BTC_IDX_FFPAR 4'h7
`define BTC_IDX_FAULT 4'h8

// Control word bit positions
`define BTC_MB_FAST 1
`define BTC_MB_NT_INH 2
`define BTC_MB_CLR_FLT 3
`define BTC_MB_PD_ZERO 4
`define BTC_MB_FREEZE 5
`define BTC_MB_SYSRST 6
`define BTC_MB_HE_CAP 7
`define BTC_MB_HE_ADP 8
`define BTC_MB_NT_ADP 9
`define BTC_MB_TB_ADP 10
`define BTC_MB_NT_CAP 11
`define BTC_MB_TB_CAP 12

// Beam type codes
`define BTC_BEAM_HE 2'h0
`define BTC_BEAM_NT 2'h1
`define BTC_BEAM_TB 2'h2
`define BTC_BEAM_NONE 2'h3

// Reset values
`define BTC_MODE_RST 16'h0000
`define BTC_BIDX_RST 2'h0

// Sampling periods in ns and clock period in ns
`define BTC_CLK_NS 100
`define BTC_SLOW_NS 192
`define BTC_FAST_NS 16
// Cycles per sample, at least one cycle each
`define BTC_SLOW_CYC ((`BTC_SLOW_NS + `BTC_CLK_NS - 1) / `BTC_CLK_NS)
`define BTC_FAST_CYC ((`BTC_FAST_NS + `BTC_CLK_NS - 1) / `BTC_CLK_NS)

`endif

// *** hdl/btc_sample_div.v ***
// Sample-rate divider: one-cycle enable at the slow or fast sampling period.
// Assumes one clock; counts always and strobes only while run_i is high.
`timescale 1ns/1ps
`include "btc_consts.vh"
module btc_sample_div
(
    input wire clk_i, // System clock
    input wire rst_i, // Synchronous reset
    input wire fast_i, // Select fast sampling
    input wire run_i, // Allow strobes
    output reg sample_o // One-cycle sample strobe
);
    localparam integer SLOW_I = `BTC_SLOW_CYC;
    localparam integer FAST_I = `BTC_FAST_CYC;
    // Counts are small, so the low byte holds them whole
    localparam [7:0] SLOW_CNT = SLOW_I[7:0];
    localparam [7:0] FAST_CNT = FAST_I[7:0];
    reg [7:0] cnt_reg;
    wire [7:0] lim;

    assign lim = fast_i ? FAST_CNT : SLOW_CNT;

    // Count up the period and pulse at wrap
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 8'h00;
            sample_o <= 1'b0;
        end
        else if (cnt_reg + 8'h01 >= lim)
        begin
            cnt_reg <= 8'h00;
            sample_o <= run_i;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
            sample_o <= 1'b0;
        end
    end
endmodule

// *** hdl/btc_window_gen.v ***
// Window generator: after a trigger, waits a start offset then opens a gate for a width.
// Assumes trigger is a one-cycle pulse and settings are stable during a cycle.
`timescale 1ns/1ps
module btc_window_gen #(
    parameter W = 16
)
(
    input wire clk_i, // System clock
    input wire rst_i, // Synchronous reset
    input wire trig_i, // Start pulse
    input wire [W-1:0] start_i, // Offset to window open
    input wire [W-1:0] width_i, // Window width
    output reg gate_o // Window gate
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_OPEN = 2'h2;
    reg [1:0] state_reg;
    reg [W-1:0] cnt_reg;

    // Delay then gate state machine
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= {W{1'b0}};
            gate_o <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    gate_o <= 1'b0;
                    if (trig_i)
                    begin
                        cnt_reg <= start_i;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (cnt_reg == {W{1'b0}})
                    begin
                        cnt_reg <= width_i;
                        gate_o <= (width_i != {W{1'b0}});
                        state_reg <= (width_i != {W{1'b0}}) ? ST_OPEN : ST_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
                ST_OPEN:
                begin
                    if (cnt_reg <= {{(W-1){1'b0}}, 1'b1})
                    begin
                        gate_o <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
                default:
                begin
                    gate_o <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** hdl/btc_top.v ***
// Beam-type capture and feed-forward control: Wishbone registers, capture trigger
// select and masking, two beam-loading windows with slope readback, adaptive update gate.
// Assumes timing inputs synchronous to clk_i and a classic Wishbone master.
`timescale 1ns/1ps
`include "btc_consts.vh"
module btc_top #(
    parameter PW = 16,
    parameter SW = 18
)
(
    input wire clk_i, // System clock, 10 MHz
    input wire rst_i, // Synchronous reset, active high
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [5:0] wb_adr_i, // Wishbone byte address
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    input wire cycle_start_trigger_i, // Cycle start pulse
    input wire prepulse_i, // Beam prepulse pulse
    input wire beam_sensor_input_i, // Beam sensor level
    input wire [1:0] beam_type_i, // Decoded beam type
    input wire [2:0] beam_present_i, // Presence per beam type
    input wire cycle_end_i, // End of RF cycle pulse
    input wire fault_event_i, // Fault counting pulse
    input wire drift_step_i, // Phase drift step pulse
    input wire [PW-1:0] gradient_i, // Gradient sample
    output reg fast_sample_select_o, // Fast sampling selected
    output reg sample_strobe_o, // Capture sample strobe
    output reg capture_start_o, // Capture trigger pulse
    output reg capture_source_o, // 1 prepulse, 0 cycle start
    output reg beam_selected_o, // Selected beam present
    output reg first_window_gate_o, // First loading window
    output reg second_window_gate_o, // Second loading window
    output reg ff_enable_o, // Feed-forward pulse allowed
    output reg adaptive_update_o, // Table update strobe
    output reg [PW-1:0] ff_param_o, // Parameter for current beam
    output reg timing_reset_o // Timing reset level
);
    reg [15:0] mode_reg;
    reg [1:0] bidx_reg;
    reg [PW-1:0] fws_reg;
    reg [PW-1:0] sws_reg;
    reg [PW-1:0] wwid_reg;
    reg [PW-1:0] par_mem [0:2];
    reg [SW-1:0] slope_reg;
    reg [PW-1:0] samp1_reg;
    reg [15:0] fault_reg;
    reg [15:0] drift_reg;
    reg upd_en_reg;
    reg g1_d_reg;
    reg g2_d_reg;
    reg [31:0] rd_next;
    wire acc;
    wire wr;
    wire [3:0] idx;
    wire [2:0] cap_en;
    wire [2:0] adp_en;
    wire cap_sel;
    wire present_sel;
    wire tim_rst;
    wire g1;
    wire g2;
    wire smp;
    wire adaptive_sel;
    wire [SW-1:0] diff;

    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = acc & wb_we_i;
    assign idx = wb_adr_i[5:2];
    assign cap_en = {mode_reg[`BTC_MB_TB_CAP], mode_reg[`BTC_MB_NT_CAP],
                     mode_reg[`BTC_MB_HE_CAP]};
    assign adp_en = {mode_reg[`BTC_MB_TB_ADP], mode_reg[`BTC_MB_NT_ADP],
                     mode_reg[`BTC_MB_HE_ADP]};
    // source select is OR of enables
    assign cap_sel = |cap_en;
    assign present_sel = |(beam_present_i & cap_en);
    assign tim_rst = rst_i | mode_reg[`BTC_MB_SYSRST];
    // index decode, code 3 means none
    assign adaptive_sel = (beam_type_i == `BTC_BEAM_NONE) ? 1'b0 : adp_en[beam_type_i];
    assign diff = {{(SW-PW){gradient_i[PW-1]}}, gradient_i}
                - {{(SW-PW){samp1_reg[PW-1]}}, samp1_reg};

    btc_sample_div u_div (
        .clk_i(clk_i),
        .rst_i(tim_rst),
        .fast_i(mode_reg[`BTC_MB_FAST]),
        .run_i(~mode_reg[`BTC_MB_FREEZE]),
        .sample_o(smp)
    );

    btc_window_gen #(.W(PW)) u_win1 (
        .clk_i(clk_i),
        .rst_i(tim_rst),
        .trig_i(prepulse_i),
        .start_i(fws_reg),
        .width_i(wwid_reg),
        .gate_o(g1)
    );

    btc_window_gen #(.W(PW)) u_win2 (
        .clk_i(clk_i),
        .rst_i(tim_rst),
        .trig_i(prepulse_i),
        .start_i(sws_reg),
        .width_i(wwid_reg),
        .gate_o(g2)
    );

    // Register writes, all take effect on the clock edge
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= `BTC_MODE_RST;
            bidx_reg <= `BTC_BIDX_RST;
            fws_reg <= {PW{1'b0}};
            sws_reg <= {PW{1'b0}};
            wwid_reg <= {PW{1'b0}};
        end
        else if (wr)
        begin
            // unused mode bits stored as written
            if (idx == `BTC_IDX_MODE)
            begin
                if (wb_sel_i[0])
                    mode_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    mode_reg[15:8] <= wb_dat_i[15:8];
            end
            else if (idx == `BTC_IDX_BEAM)
            begin
                if (wb_sel_i[0])
                    bidx_reg <= wb_dat_i[1:0];
            end
            else if (idx == `BTC_IDX_FWS)
            begin
                if (wb_sel_i[0])
                    fws_reg <= wb_dat_i[PW-1:0];
            end
            else if (idx == `BTC_IDX_SWS)
            begin
                if (wb_sel_i[0])
                    sws_reg <= wb_dat_i[PW-1:0];
            end
            else if (idx == `BTC_IDX_WWID)
            begin
                if (wb_sel_i[0])
                    wwid_reg <= wb_dat_i[PW-1:0];
            end
        end
    end

    // Beam-dependent parameter copies, one per beam type
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_par
            always @(posedge clk_i)
            begin
                if (rst_i)
                    par_mem[gi] <= {PW{1'b0}};
                else if (wr && wb_sel_i[0] && idx == `BTC_IDX_FFPAR && bidx_reg == gi)
                    par_mem[gi] <= wb_dat_i[PW-1:0];
            end
        end
    endgenerate

    // Fault counter and phase drift accumulator
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_reg <= 16'h0000;
            drift_reg <= 16'h0000;
        end
        else
        begin
            // clear bits hold values at zero
            if (mode_reg[`BTC_MB_CLR_FLT])
                fault_reg <= 16'h0000;
            else if (fault_event_i && fault_reg != 16'hFFFF)
                fault_reg <= fault_reg + 16'h0001;
            if (mode_reg[`BTC_MB_PD_ZERO])
                drift_reg <= 16'h0000;
            else if (drift_step_i)
                drift_reg <= drift_reg + 16'h0001;
        end
    end

    // Window sampling, slope, and update latch; timing on the device clock
    always @(posedge clk_i)
    begin
        if (tim_rst)
        begin
            g1_d_reg <= 1'b0;
            g2_d_reg <= 1'b0;
            samp1_reg <= {PW{1'b0}};
            slope_reg <= {SW{1'b0}};
            upd_en_reg <= 1'b0;
        end
        else
        begin
            g1_d_reg <= g1;
            g2_d_reg <= g2;
            // sensor caught at first window rise
            if (g1 && !g1_d_reg)
                upd_en_reg <= beam_sensor_input_i;
            if (g1 && !g1_d_reg)
                samp1_reg <= gradient_i;
            if (g2 && !g2_d_reg)
                slope_reg <= diff;
        end
    end

    // Registered outputs
    always @(posedge clk_i)
    begin
        if (tim_rst)
        begin
            fast_sample_select_o <= 1'b0;
            sample_strobe_o <= 1'b0;
            capture_start_o <= 1'b0;
            capture_source_o <= 1'b0;
            beam_selected_o <= 1'b0;
            first_window_gate_o <= 1'b0;
            second_window_gate_o <= 1'b0;
            ff_enable_o <= 1'b0;
            adaptive_update_o <= 1'b0;
            ff_param_o <= {PW{1'b0}};
            timing_reset_o <= ~rst_i;
        end
        else
        begin
            timing_reset_o <= 1'b0;
            fast_sample_select_o <= mode_reg[`BTC_MB_FAST];
            sample_strobe_o <= smp & ~mode_reg[`BTC_MB_FREEZE];
            capture_source_o <= cap_sel;
            beam_selected_o <= present_sel;
            // trigger from prepulse or cycle start
            capture_start_o <= (cap_sel ? prepulse_i : cycle_start_trigger_i)
                               & ~mode_reg[`BTC_MB_FREEZE];
            first_window_gate_o <= g1;
            second_window_gate_o <= g2;
            // inhibit on neutron beam when set
            ff_enable_o <= (beam_type_i != `BTC_BEAM_NONE) &&
                           !(mode_reg[`BTC_MB_NT_INH] && beam_type_i == `BTC_BEAM_NT);
            adaptive_update_o <= cycle_end_i & upd_en_reg & adaptive_sel;
            ff_param_o <= (beam_type_i == `BTC_BEAM_NONE) ? {PW{1'b0}} : par_mem[beam_type_i];
        end
    end

    // Read mux by address
    always @*
    begin
        rd_next = 32'h00000000;
        if (idx == `BTC_IDX_MODE)
            rd_next[15:0] = mode_reg;
        else if (idx == `BTC_IDX_BEAM)
            rd_next[1:0] = bidx_reg;
        else if (idx == `BTC_IDX_FWS)
            rd_next[PW-1:0] = fws_reg;
        else if (idx == `BTC_IDX_SWS)
            rd_next[PW-1:0] = sws_reg;
        else if (idx == `BTC_IDX_WWID)
            rd_next[PW-1:0] = wwid_reg;
        else if (idx == `BTC_IDX_SLOPE)
            rd_next[SW-1:0] = slope_reg;
        else if (idx == `BTC_IDX_STAT)
            rd_next[3:0] = {upd_en_reg, g2_d_reg, g1_d_reg, present_sel};
        else if (idx == `BTC_IDX_FFPAR)
            rd_next[PW-1:0] = (bidx_reg == `BTC_BEAM_NONE) ? {PW{1'b0}} : par_mem[bidx_reg];
        else if (idx == `BTC_IDX_FAULT)
            rd_next = {drift_reg, fault_reg};
    end

    // Wishbone ack one cycle after request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= acc;
            wb_dat_o <= acc ? rd_next : 32'h00000000;
        end
    end
endmodule

// *** tb/btc_top_sva.sv ***
// Checker for the beam-type control block, bound to its top module.
// Sees only the top module's ports; one clock with a synchronous reset.
`timescale 1ns/1ps
module btc_top_sva #(
    parameter PW = 16
)
(
    input wire clk_i, // Clock
    input wire rst_i, // Reset
    input wire wb_cyc_i, // Bus cycle
    input wire wb_stb_i, // Bus strobe
    input wire wb_ack_o, // Bus acknowledge
    input wire [31:0] wb_dat_o, // Read data
    input wire cycle_start_trigger_i, // Cycle start pulse
    input wire prepulse_i, // Beam prepulse
    input wire cycle_end_i, // Cycle end pulse
    input wire [2:0] beam_present_i, // Presence per beam
    input wire [1:0] beam_type_i, // Decoded beam word
    input wire fast_sample_select_o, // Fast sampling
    input wire sample_strobe_o, // Sample strobe
    input wire capture_start_o, // Capture trigger
    input wire capture_source_o, // Capture source
    input wire beam_selected_o, // Selected beam flag
    input wire first_window_gate_o, // First window
    input wire second_window_gate_o, // Second window
    input wire ff_enable_o, // Feed-forward allowed
    input wire adaptive_update_o, // Table update strobe
    input wire timing_reset_o, // Timing reset level
    input wire [PW-1:0] ff_param_o // Parameter copy
);
    logic pp_seen;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Remembers that a prepulse arrived since reset
    always @(posedge clk_i)
    begin
        if (rst_i)
            pp_seen <= 1'b0;
        else if (prepulse_i)
            pp_seen <= 1'b1;
    end
    a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    a_slow_period: assert property (!fast_sample_select_o [*3] ##0 sample_strobe_o
        |=> !sample_strobe_o || fast_sample_select_o) else $error("slow strobe too close");
    a_trig_source: assert property (capture_start_o |-> (capture_source_o ?
        $past(prepulse_i) : $past(cycle_start_trigger_i))) else $error("wrong capture source");
    a_beam_mask: assert property (beam_selected_o |-> $past(|beam_present_i))
        else $error("beam flag without presence");
    a_win_prepulse: assert property ($rose(first_window_gate_o) ||
        $rose(second_window_gate_o) |-> pp_seen) else $error("window without prepulse");
    a_upd_gate: assert property (adaptive_update_o |-> $past(cycle_end_i))
        else $error("update strobe outside cycle end");
    a_no_beam: assert property ((beam_type_i == 2'h3) [*2] |->
        !ff_enable_o && ff_param_o == '0) else $error("feed-forward active with no beam");
    a_trst_quiet: assert property (timing_reset_o && $past(timing_reset_o) |->
        !first_window_gate_o && !second_window_gate_o) else $error("window under reset");
    c_update: cover property (adaptive_update_o);
    c_second_win: cover property ($rose(second_window_gate_o));
    c_beam_capture: cover property (capture_start_o && capture_source_o);
endmodule
bind btc_top btc_top_sva #(.PW(PW)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cycle_start_trigger_i(cycle_start_trigger_i),
    .prepulse_i(prepulse_i), .cycle_end_i(cycle_end_i), .beam_present_i(beam_present_i),
    .beam_type_i(beam_type_i), .fast_sample_select_o(fast_sample_select_o),
    .sample_strobe_o(sample_strobe_o), .capture_start_o(capture_start_o),
    .capture_source_o(capture_source_o), .beam_selected_o(beam_selected_o),
    .first_window_gate_o(first_window_gate_o), .second_window_gate_o(second_window_gate_o),
    .ff_enable_o(ff_enable_o), .adaptive_update_o(adaptive_update_o),
    .timing_reset_o(timing_reset_o), .ff_param_o(ff_param_o)
);

// *** tb/btc_wb_master.sv ***
// Model of the controlling processor: a classic Wishbone master.
// Callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
`include "btc_consts.vh"
module btc_wb_master
(
    input wire clk_i, // Clock
    input wire ack_i, // Acknowledge
    input wire [31:0] dat_i, // Read data
    output logic cyc_o = 1'b0, // Cycle
    output logic stb_o = 1'b0, // Strobe
    output logic we_o = 1'b0, // Write enable
    output logic [3:0] sel_o = 4'h0, // Byte selects
    output logic [5:0] adr_o = 6'h0, // Byte address
    output logic [31:0] dat_o = 32'h0 // Write data
);
    // One cycle held until ack is seen; released address and data lines show inverted values
    task xfer(input logic w, input logic [3:0] i, input logic [31:0] d,
              input logic [3:0] s, output logic [31:0] q);
        begin
            cyc_o <= 1'b1;
            stb_o <= 1'b1;
            we_o <= w;
            sel_o <= s;
            adr_o <= {i, 2'b00};
            dat_o <= d;
            do @(posedge clk_i); while (ack_i !== 1'b1);
            q = dat_i;
            cyc_o <= 1'b0;
            stb_o <= 1'b0;
            adr_o <= ~{i, 2'b00};
            dat_o <= ~d;
            @(posedge clk_i);
        end
    endtask
    task set_param(input logic [1:0] b, input logic [15:0] v);
        logic [31:0] q;
        begin
            xfer(1'b1, `BTC_IDX_BEAM, {30'h0, b}, 4'hF, q);
            xfer(1'b1, `BTC_IDX_FFPAR, {16'h0, v}, 4'hF, q);
        end
    endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench for the beam-type control block: register traffic through the
// processor model, timing pulses and output tallies. Assumes a 10 MHz clock.
`timescale 1ns/1ps
`include "btc_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic clk_i, rst_i = 1'b1, cyc, stb, we, ack, sens = 1'b0, g1d, g2d;
    logic fso, sso, cap, csrc, bsel, g1, g2, ffe, upd, trst;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] wdat, rdat, dout;
    logic [4:0] pls = 5'h0;
    logic [1:0] btype = 2'h0;
    logic [2:0] bpres = 3'h0;
    logic [15:0] ffp;
    int cyc_n, n_str, n_cap, n_upd, w1, w2, t1, t2, b0, b1, b2, fails, n_checks;
    wire [15:0] grad = cyc_n[15:0];
    btc_wb_master m (.clk_i(clk_i), .ack_i(ack), .dat_i(dout), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
    btc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .cycle_start_trigger_i(pls[0]), .prepulse_i(pls[1]), .cycle_end_i(pls[2]),
        .fault_event_i(pls[3]), .drift_step_i(pls[4]), .beam_sensor_input_i(sens),
        .beam_type_i(btype), .beam_present_i(bpres), .gradient_i(grad),
        .fast_sample_select_o(fso), .sample_strobe_o(sso), .capture_start_o(cap),
        .capture_source_o(csrc), .beam_selected_o(bsel), .first_window_gate_o(g1),
        .second_window_gate_o(g2), .ff_enable_o(ffe), .adaptive_update_o(upd),
        .ff_param_o(ffp), .timing_reset_o(trst));
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Ramp, output tallies, window rise times and the run ceiling
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
        n_str <= n_str + sso;
        n_cap <= n_cap + cap;
        n_upd <= n_upd + upd;
        w1 <= w1 + g1;
        w2 <= w2 + g2;
        g1d <= g1;
        g2d <= g2;
        if (g1 && !g1d)
            t1 <= cyc_n;
        if (g2 && !g2d)
            t2 <= cyc_n;
        if (cyc_n == 8000)
        begin
            fails++;
            conclude();
        end
    end
    task conclude;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wr(input logic [3:0] i, input logic [31:0] v, input logic [3:0] s = 4'hF);
        m.xfer(1'b1, i, v, s, rdat);
    endtask
    task rd(input logic [3:0] i, input logic [31:0] e);
        begin
            m.xfer(1'b0, i, 32'h0, 4'hF, rdat);
            `CHK(rdat, e)
        end
    endtask
    task pulse(input logic [4:0] p);
        begin
            pls <= p;
            @(posedge clk_i);
            pls <= 5'h0;
            @(posedge clk_i);
        end
    endtask
    // Main sequence
    initial
    begin
        wt(10);
        rst_i <= 1'b0;
        wt(1);
        for (int i = 0; i < 16; i++) rd(i[3:0], 32'h0);
        wr(4'h9, 32'h1234);
        rd(4'h9, 32'h0);
        wr(`BTC_IDX_MODE, 32'hFFFF, 4'h1);
        rd(`BTC_IDX_MODE, 32'h00FF);
        wr(`BTC_IDX_MODE, 32'hE001, 4'h3);
        rd(`BTC_IDX_MODE, 32'hE001);
        wt(3);
        `CHK({fso, csrc, trst}, 3'h0)
        $display("test registers done");
        for (int f = 0; f < 2; f++)
        begin
            wr(`BTC_IDX_MODE, f << 1);
            wt(3);
            b0 = n_str;
            wt(20);
            `CHK(n_str - b0, f ? 20 : 10)
            `CHK(fso, f[0])
        end
        wr(`BTC_IDX_MODE, 32'h20);
        wt(3);
        b0 = n_str;
        b1 = n_cap;
        pulse(5'h1);
        wt(16);
        `CHK(n_str - b0, 0)
        `CHK(n_cap - b1, 0)
        $display("test sampling done");
        wr(`BTC_IDX_MODE, 32'h0);
        b1 = n_cap;
        pulse(5'h1);
        pulse(5'h2);
        wt(4);
        `CHK(n_cap - b1, 1)
        for (int j = 0; j < 3; j++)
        begin
            wr(`BTC_IDX_MODE, 32'h1 << (j == 0 ? 7 : 10 + j));
            wt(3);
            `CHK(csrc, 1'b1)
            for (int i = 0; i < 3; i++)
            begin
                bpres <= 3'h1 << i;
                wt(3);
                `CHK(bsel, i == j)
                rd(`BTC_IDX_STAT, i == j);
            end
            bpres <= 3'h0;
            b1 = n_cap;
            pulse(5'h1);
            pulse(5'h2);
            wt(4);
            `CHK(n_cap - b1, 1)
        end
        $display("test capture done");
        wr(`BTC_IDX_FWS, 32'h2);
        wr(`BTC_IDX_SWS, 32'h6);
        wr(`BTC_IDX_WWID, 32'h3);
        b0 = w1;
        pulse(5'h1);
        wt(16);
        `CHK(w1 - b0, 0)
        for (int k = 0; k < 3; k++)
        begin
            wr(`BTC_IDX_MODE, 32'h100 << k);
            btype <= k[1:0];
            sens <= 1'b1;
            b0 = w1;
            b1 = w2;
            pulse(5'h2);
            wt(16);
            `CHK(w1 - b0, 3)
            `CHK(w2 - b1, 3)
            `CHK(t2 - t1, 4)
            // processor reads slope for its tilt loop
            rd(`BTC_IDX_SLOPE, 32'h4);
            b2 = n_upd;
            pulse(5'h4);
            wt(3);
            `CHK(n_upd - b2, 1)
            btype <= (k == 2) ? 2'h0 : k[1:0] + 2'h1;
            wt(3);
            pulse(5'h4);
            wt(3);
            `CHK(n_upd - b2, 1)
            btype <= k[1:0];
            sens <= 1'b0;
            pulse(5'h2);
            wt(16);
            pulse(5'h4);
            wt(3);
            `CHK(n_upd - b2, 1)
        end
        $display("test windows done");
        for (int k = 0; k < 3; k++) m.set_param(k[1:0], 16'hA5A0 + k);
        wr(`BTC_IDX_MODE, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(`BTC_IDX_BEAM, k);
            rd(`BTC_IDX_FFPAR, 32'hA5A0 + k);
            btype <= k[1:0];
            wt(3);
            `CHK(ffp, 16'hA5A0 + k[15:0])
            `CHK(ffe, 1'b1)
        end
        btype <= 2'h3;
        wt(3);
        `CHK({ffe, ffp}, 17'h0)
        wr(`BTC_IDX_MODE, 32'h4);
        btype <= 2'h1;
        wt(3);
        `CHK(ffe, 1'b0)
        btype <= 2'h2;
        wt(3);
        `CHK(ffe, 1'b1)
        $display("test parameters done");
        wr(`BTC_IDX_MODE, 32'h0);
        for (int k = 0; k < 3; k++) pulse(5'h8);
        pulse(5'h10);
        rd(`BTC_IDX_FAULT, 32'h00010003);
        wr(`BTC_IDX_MODE, 32'h18);
        wt(2);
        rd(`BTC_IDX_FAULT, 32'h0);
        wr(`BTC_IDX_MODE, 32'h40);
        wt(3);
        `CHK(trst, 1'b1)
        b0 = w1;
        pulse(5'h2);
        wt(16);
        `CHK(w1 - b0, 0)
        $display("test counters and timing reset done");
        conclude();
    end
endmodule
